// File: rtl/sia_top.sv
`timescale 1ns/10ps
// What this block does
// - Reverse subtract: W minus f minus not-carry
// - Decode 010101da; update N OV C DC Z
// - Dest bit 0 to W, 1 to file
// - Access bit 0 access bank, 1 bank select
// - Extended set, a=0, f<=95: indexed offset
// - File ops: decode, read, process, write phases
// - Literal minus W, result into W
// - Literal: decode, read literal, process, write W
// - Literal and file subtracts update five flags
// - File minus W, decoded from 010111da
// - Carry is inverted borrow; Z, N from result
module sia_top (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [15:0] instr_word,
   input wire logic instr_valid,
   input wire logic ext_set_enable,
   input wire logic [3:0] bank_select_register,
   input wire logic [11:0] index_base,
   input wire logic [7:0] file_rd_data,
   input wire logic w_load,
   input wire logic [7:0] w_load_data,
   input wire logic flags_load,
   input wire logic [4:0] flags_load_data,
   output logic [1:0] phase,
   output logic instr_taken,
   output logic unsupported,
   output logic [11:0] file_addr,
   output logic file_rd_en,
   output logic file_wr_en,
   output logic [7:0] file_wr_data,
   output logic [7:0] w_out,
   output logic [4:0] status_flags
);
   sia_pkg::sia_phase_e phase_reg, phase_next;
   sia_pkg::sia_op_e op_reg, op_dec;
   logic [15:0] instr_reg;
   logic [7:0] operand_reg;
   logic [7:0] result_reg;
   logic [4:0] result_flags_reg;
   logic [7:0] w_reg;
   logic [4:0] flags_reg;
   logic [11:0] addr_reg;
   logic rd_en_reg;
   logic wr_en_reg;
   logic taken_reg;
   logic unsup_reg;

   sia_sub_if sub ();

   sia_sub_unit u_sub (
      .sub(sub)
   );

   // Decode of the incoming word during Q1
   logic [5:0] in_op6;
   logic [7:0] in_op8;
   logic [7:0] in_f;
   logic in_access;
   logic in_indexed;
   logic [11:0] in_addr;
   logic accept;

   assign in_op6 = instr_word[sia_pkg::OP6_MSB:sia_pkg::OP6_LSB];
   assign in_op8 = instr_word[sia_pkg::OP6_MSB:sia_pkg::OP8_LSB];
   assign in_f = instr_word[7:0];
   assign in_access = instr_word[sia_pkg::ACCESS_BIT];

   always_comb begin
      if (in_op6 == sia_pkg::OP_REV_SUB_BORROW) begin
         op_dec = sia_pkg::SIA_OP_REV_SUB;
      end else if (in_op6 == sia_pkg::OP_FILE_MINUS_ACC) begin
         op_dec = sia_pkg::SIA_OP_FILE_SUB;
      end else if (in_op8 == sia_pkg::OP_LIT_MINUS_ACC) begin
         op_dec = sia_pkg::SIA_OP_LIT_SUB;
      end else begin
         op_dec = sia_pkg::SIA_OP_NONE;
      end
   end

   assign in_indexed = ext_set_enable && !in_access && (in_f <= sia_pkg::INDEXED_MAX);

   assign in_addr = in_indexed ? (index_base + {4'h0, in_f}) :
                    in_access ? {bank_select_register, in_f} :
                    (in_f < sia_pkg::ACCESS_SPLIT) ? {sia_pkg::ACCESS_LOW_BANK, in_f} :
                    {sia_pkg::ACCESS_HIGH_BANK, in_f};

   assign accept = (phase_reg == sia_pkg::SIA_Q1) && instr_valid;

   // Free-running phase counter; the instruction cycle never stretches
   always_comb begin
      case (phase_reg)
         sia_pkg::SIA_Q1: phase_next = sia_pkg::SIA_Q2;
         sia_pkg::SIA_Q2: phase_next = sia_pkg::SIA_Q3;
         sia_pkg::SIA_Q3: phase_next = sia_pkg::SIA_Q4;
         sia_pkg::SIA_Q4: phase_next = sia_pkg::SIA_Q1;
         default: phase_next = sia_pkg::SIA_Q1;
      endcase
   end

   // Operand selection for the subtractor
   logic is_file_op;
   logic dest_file;
   logic in_q1, in_q2, in_q3, in_q4;

   assign in_q1 = (phase_reg == sia_pkg::SIA_Q1);
   assign in_q2 = (phase_reg == sia_pkg::SIA_Q2);
   assign in_q3 = (phase_reg == sia_pkg::SIA_Q3);
   assign in_q4 = (phase_reg == sia_pkg::SIA_Q4);
   assign is_file_op = (op_reg == sia_pkg::SIA_OP_REV_SUB) ||
                       (op_reg == sia_pkg::SIA_OP_FILE_SUB);
   assign dest_file = is_file_op && instr_reg[sia_pkg::DEST_BIT];

   always_comb begin
      case (op_reg)
         sia_pkg::SIA_OP_REV_SUB: begin
            sub.minuend = w_reg;
            sub.subtrahend = operand_reg;
            sub.no_borrow_in = flags_reg[sia_pkg::FLAG_C];
         end
         sia_pkg::SIA_OP_LIT_SUB: begin
            sub.minuend = operand_reg;
            sub.subtrahend = w_reg;
            sub.no_borrow_in = 1'b1;
         end
         sia_pkg::SIA_OP_FILE_SUB: begin
            sub.minuend = operand_reg;
            sub.subtrahend = w_reg;
            sub.no_borrow_in = 1'b1;
         end
         default: begin
            sub.minuend = 8'h00;
            sub.subtrahend = 8'h00;
            sub.no_borrow_in = 1'b1;
         end
      endcase
   end

   // Next values of the read, operand and write stages
   logic [7:0] operand_next;
   logic [7:0] w_next;
   logic [4:0] flags_next;
   logic do_write;

   assign do_write = in_q4 && (op_reg != sia_pkg::SIA_OP_NONE);

   assign operand_next = !in_q2 ? operand_reg :
                         is_file_op ? file_rd_data : instr_reg[7:0];

   // Core loads lose to a subtract writing W in the same Q4
   // result to W when dest is 0
   assign w_next = (do_write && !dest_file) ? result_reg :
                   w_load ? w_load_data : w_reg;
   assign flags_next = do_write ? result_flags_reg :
                       flags_load ? flags_load_data : flags_reg;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         phase_reg <= sia_pkg::SIA_Q1;
      end else begin
         phase_reg <= phase_next;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         instr_reg <= 16'h0000;
         op_reg <= sia_pkg::SIA_OP_NONE;
         addr_reg <= 12'h000;
         taken_reg <= 1'b0;
         unsup_reg <= 1'b0;
      end else if (in_q1) begin
         instr_reg <= instr_word;
         op_reg <= accept ? op_dec : sia_pkg::SIA_OP_NONE;
         addr_reg <= in_addr;
         taken_reg <= accept && (op_dec != sia_pkg::SIA_OP_NONE);
         unsup_reg <= accept && (op_dec == sia_pkg::SIA_OP_NONE);
      end else begin
         taken_reg <= 1'b0;
         unsup_reg <= 1'b0;
      end
   end

   // Read strobe stands for Q2 only; data is sampled at Q2's end
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rd_en_reg <= 1'b0;
         operand_reg <= 8'h00;
      end else begin
         rd_en_reg <= in_q1 && accept &&
                      ((op_dec == sia_pkg::SIA_OP_REV_SUB) ||
                       (op_dec == sia_pkg::SIA_OP_FILE_SUB));
         operand_reg <= operand_next;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         result_reg <= 8'h00;
         result_flags_reg <= sia_pkg::FLAGS_RESET;
      end else if (in_q3) begin
         result_reg <= sub.result;
         result_flags_reg <= sub.flags;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         wr_en_reg <= 1'b0;
      end else begin
         wr_en_reg <= in_q3 && dest_file;
      end
   end

   // W and flags take subtract results at Q4 and core loads in any phase
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         w_reg <= sia_pkg::W_RESET;
         flags_reg <= sia_pkg::FLAGS_RESET;
      end else begin
         w_reg <= w_next;
         flags_reg <= flags_next;
      end
   end

   assign phase = phase_reg;
   assign instr_taken = taken_reg;
   assign unsupported = unsup_reg;
   assign file_addr = addr_reg;
   assign file_rd_en = rd_en_reg;
   assign file_wr_en = wr_en_reg;
   assign file_wr_data = result_reg;
   assign w_out = w_reg;
   assign status_flags = flags_reg;
endmodule // sia_top

// File: include/sia_pkg.sv
package sia_pkg;
   // Opcode fields of the upper instruction bits
   localparam logic [5:0] OP_REV_SUB_BORROW = 6'h15;
   localparam logic [5:0] OP_FILE_MINUS_ACC = 6'h17;
   localparam logic [7:0] OP_LIT_MINUS_ACC = 8'h08;
   // Field positions in the instruction word
   localparam int OP6_MSB = 15;
   localparam int OP6_LSB = 10;
   localparam int OP8_LSB = 8;
   localparam int DEST_BIT = 9;
   localparam int ACCESS_BIT = 8;
   // Indexed literal offset window and access bank split
   localparam logic [7:0] INDEXED_MAX = 8'h5F;
   localparam logic [7:0] ACCESS_SPLIT = 8'h60;
   localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
   localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;
   // Reset values
   localparam logic [7:0] W_RESET = 8'h00;
   localparam logic [4:0] FLAGS_RESET = 5'h00;
   // Flag positions in the status vector {n, ov, z, dc, c}
   localparam int FLAG_C = 0;
   localparam int FLAG_DC = 1;
   localparam int FLAG_Z = 2;
   localparam int FLAG_OV = 3;
   localparam int FLAG_N = 4;
   // Instruction cycle: four clocks, one per phase
   localparam int PHASES_PER_CYCLE = 4;

   typedef enum logic [1:0] {
      SIA_Q1,
      SIA_Q2,
      SIA_Q3,
      SIA_Q4
   } sia_phase_e;

   typedef enum logic [1:0] {
      SIA_OP_NONE,
      SIA_OP_REV_SUB,
      SIA_OP_LIT_SUB,
      SIA_OP_FILE_SUB
   } sia_op_e;
endpackage

// File: include/sia_sub_if.sv
`timescale 1ns/10ps
interface sia_sub_if;
   logic [7:0] minuend;
   logic [7:0] subtrahend;
   logic no_borrow_in;
   logic [7:0] result;
   logic [4:0] flags;

   modport unit (
      input minuend,
      input subtrahend,
      input no_borrow_in,
      output result,
      output flags
   );
   modport user (
      output minuend,
      output subtrahend,
      output no_borrow_in,
      input result,
      input flags
   );
endinterface // sia_sub_if

// File: rtl/sia_sub_unit.sv
`timescale 1ns/10ps
module sia_sub_unit (
   sia_sub_if.unit sub
);
   logic [4:0] low_sum;
   logic [8:0] full_sum;
   logic [7:0] res;
   logic [4:0] flag_vec;

   // Two's complement: a + ~b + carry, so carry out is the inverted borrow
   assign low_sum = {1'b0, sub.minuend[3:0]} + {1'b0, ~sub.subtrahend[3:0]}
                    + {4'h0, sub.no_borrow_in};
   assign full_sum = {1'b0, sub.minuend} + {1'b0, ~sub.subtrahend}
                     + {8'h00, sub.no_borrow_in};
   assign res = full_sum[7:0];

   assign flag_vec[sia_pkg::FLAG_C] = full_sum[8];
   assign flag_vec[sia_pkg::FLAG_DC] = low_sum[4];
   assign flag_vec[sia_pkg::FLAG_Z] = (res == 8'h00);
   assign flag_vec[sia_pkg::FLAG_OV] = (sub.minuend[7] != sub.subtrahend[7])
                                       && (res[7] != sub.minuend[7]);
   assign flag_vec[sia_pkg::FLAG_N] = res[7];

   assign sub.result = res;
   assign sub.flags = flag_vec;
endmodule // sia_sub_unit

// File: test/sia_top_monitor.sv
`timescale 1ns/10ps
module sia_top_monitor (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [15:0] instr_word,
   input wire logic instr_valid,
   input wire logic ext_set_enable,
   input wire logic [3:0] bank_select_register,
   input wire logic [11:0] index_base,
   input wire logic [7:0] file_rd_data,
   input wire logic w_load,
   input wire logic [7:0] w_load_data,
   input wire logic flags_load,
   input wire logic [4:0] flags_load_data,
   input wire logic [1:0] phase,
   input wire logic instr_taken,
   input wire logic unsupported,
   input wire logic [11:0] file_addr,
   input wire logic file_rd_en,
   input wire logic file_wr_en,
   input wire logic [7:0] file_wr_data,
   input wire logic [7:0] w_out,
   input wire logic [4:0] status_flags
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   wire take = phase == 2'h0 && instr_valid;
   sequence s_take_file;
      take && (instr_word[15:10] == 6'h15 || instr_word[15:10] == 6'h17);
   endsequence
   sequence s_take_lit;
      take && instr_word[15:8] == 8'h08;
   endsequence
   // The first edge after release still sees the reset phase
   a_phase_step: assert property (
      $past(rst_n) |-> phase == $past(phase) + 2'h1)
      else $error("phase did not advance");
   a_take_answer: assert property (
      take |=> instr_taken != unsupported)
      else $error("accepted word got no single answer");
   a_idle_quiet: assert property (
      !take |=> !instr_taken && !unsupported)
      else $error("answer pulse without a request");
   a_file_read: assert property (
      s_take_file |=> instr_taken && file_rd_en)
      else $error("file subtract not read in second phase");
   a_lit_quiet: assert property (
      s_take_lit |=> instr_taken && !file_rd_en ##2 !file_wr_en)
      else $error("literal subtract touched the file");
   a_read_phase: assert property (
      file_rd_en |-> phase == 2'h1)
      else $error("file read outside second phase");
   a_write_order: assert property (
      file_wr_en |-> phase == 2'h3 && $past(file_rd_en, 2))
      else $error("file write without read or outside last phase");
   a_dest_write: assert property (
      s_take_file |=> ##2 file_wr_en == $past(instr_word[9], 3))
      else $error("destination bit not honoured");
   a_bank_addr: assert property (
      (s_take_file and instr_word[8]) |=>
      file_addr == {$past(bank_select_register), $past(instr_word[7:0])})
      else $error("banked address wrong");
   a_lit_flags: assert property (
      s_take_lit |=> ##4 status_flags[4] == w_out[7] && status_flags[2] == (w_out == 8'h00))
      else $error("zero or negative flag disagrees with W");
endmodule // sia_top_monitor

bind sia_top sia_top_monitor mon (.clk(clk), .rst_n(rst_n), .instr_word(instr_word),
   .instr_valid(instr_valid), .ext_set_enable(ext_set_enable),
   .bank_select_register(bank_select_register), .index_base(index_base),
   .file_rd_data(file_rd_data), .w_load(w_load), .w_load_data(w_load_data),
   .flags_load(flags_load), .flags_load_data(flags_load_data), .phase(phase),
   .instr_taken(instr_taken), .unsupported(unsupported), .file_addr(file_addr),
   .file_rd_en(file_rd_en), .file_wr_en(file_wr_en), .file_wr_data(file_wr_data),
   .w_out(w_out), .status_flags(status_flags));

// File: test/tb.sv
`timescale 1ns/10ps
module tb;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [15:0] instr_word = 16'h0000;
   logic instr_valid = 1'b0;
   logic ext_set_enable = 1'b0;
   logic [3:0] bank_select_register = 4'h0;
   logic [11:0] index_base = 12'h000;
   logic [7:0] file_rd_data = 8'h00;
   logic w_load = 1'b0;
   logic [7:0] w_load_data = 8'h00;
   logic flags_load = 1'b0;
   logic [4:0] flags_load_data = 5'h00;
   logic [1:0] phase;
   logic instr_taken, unsupported, file_rd_en, file_wr_en;
   logic [11:0] file_addr;
   logic [7:0] file_wr_data, w_out;
   logic [4:0] status_flags;
   integer errors = 0;
   integer checks_done = 0;
   integer seed = 32'h77E5;
   localparam logic [32:0] CV [13] = '{
      {16'h5620, 8'h02, 8'h03, 1'h1}, {16'h5420, 8'h05, 8'h02, 1'h1},
      {16'h5620, 8'h02, 8'h01, 1'h0}, {16'h0802, 8'h01, 8'h00, 1'h0},
      {16'h0802, 8'h02, 8'h00, 1'h0}, {16'h0802, 8'h03, 8'h00, 1'h0},
      {16'h5E20, 8'h02, 8'h03, 1'h0}, {16'h5C20, 8'h02, 8'h02, 1'h0},
      {16'h5E5F, 8'h02, 8'h01, 1'h1}, {16'h5E60, 8'h80, 8'h01, 1'h1},
      {16'h5FFF, 8'h7F, 8'h80, 1'h0}, {16'h5A10, 8'h11, 8'h22, 1'h1},
      {16'h08FF, 8'hFF, 8'h00, 1'h1}};

   always #50 clk = ~clk;

   sia_top DUT (.clk(clk), .rst_n(rst_n), .instr_word(instr_word),
      .instr_valid(instr_valid), .ext_set_enable(ext_set_enable),
      .bank_select_register(bank_select_register), .index_base(index_base),
      .file_rd_data(file_rd_data), .w_load(w_load), .w_load_data(w_load_data),
      .flags_load(flags_load), .flags_load_data(flags_load_data), .phase(phase),
      .instr_taken(instr_taken), .unsupported(unsupported), .file_addr(file_addr),
      .file_rd_en(file_rd_en), .file_wr_en(file_wr_en), .file_wr_data(file_wr_data),
      .w_out(w_out), .status_flags(status_flags));

   // Returns {N, OV, Z, DC, C, result}
   function automatic logic [12:0] sub(input logic [7:0] x, y, input logic ci);
      logic [8:0] r;
      logic [4:0] h;
      r = {1'h0, x} - {1'h0, y} - {8'h00, !ci};
      h = {1'h0, x[3:0]} - {1'h0, y[3:0]} - {4'h0, !ci};
      sub = {r[7], x[7] != y[7] && r[7] != x[7], r[7:0] == 8'h00, !h[4], !r[8], r[7:0]};
   endfunction

   task automatic chk(input logic [15:0] g, e);
      checks_done++;
      if (g !== e) begin
         errors++;
         $display("mismatch at %0t got %h expected %h", $time, g, e);
      end
   endtask

   task automatic test_done;
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task automatic to_q1;
      do
         @(negedge clk);
      while (phase !== 2'h3);
      @(posedge clk);
   endtask

   // Loads W and flags in an idle slot, then offers one word in the next
   task automatic op(input logic [15:0] iw, input logic [7:0] w, f, input logic c);
      logic [4:0] fl;
      logic [3:0] b;
      logic [11:0] bs, ea;
      logic e, rv, fs, lt, wd;
      logic [12:0] x;
      fl = 5'($random(seed));
      b = 4'($random(seed));
      bs = 12'($random(seed));
      e = 1'($random(seed));
      rv = iw[15:10] == 6'h15;
      fs = iw[15:10] == 6'h17;
      lt = iw[15:8] == 8'h08;
      wd = lt || ((rv || fs) && !iw[9]);
      ea = (e && !iw[8] && iw[7:0] <= 8'h5F) ? bs + {4'h0, iw[7:0]}
         : {iw[8] ? b : (iw[7:0] >= 8'h60 ? 4'hF : 4'h0), iw[7:0]};
      x = rv ? sub(w, f, c) : fs ? sub(f, w, 1'b1) : sub(iw[7:0], w, 1'b1);
      to_q1;
      w_load <= 1'b1;
      w_load_data <= w;
      flags_load <= 1'b1;
      flags_load_data <= {fl[4:1], c};
      @(posedge clk);
      w_load <= 1'b0;
      flags_load <= 1'b0;
      to_q1;
      instr_valid <= 1'b1;
      instr_word <= iw;
      ext_set_enable <= e;
      bank_select_register <= b;
      index_base <= bs;
      @(posedge clk);
      // Offers outside the first phase must be ignored
      instr_valid <= 1'($random(seed));
      instr_word <= 16'($random(seed));
      file_rd_data <= f;
      @(negedge clk);
      chk(16'(instr_taken), 16'(rv | fs | lt));
      chk(16'(unsupported), 16'(!(rv | fs | lt)));
      chk(16'(file_rd_en), 16'(rv | fs));
      if (rv | fs) chk(16'(file_addr), 16'(ea));
      @(posedge clk);
      file_rd_data <= ~f;
      repeat (2) @(negedge clk);
      chk(16'(file_wr_en), 16'((rv | fs) & !wd));
      if ((rv | fs) & !wd) chk(16'(file_wr_data), 16'(x[7:0]));
      @(posedge clk);
      instr_valid <= 1'b0;
      @(negedge clk);
      chk(16'(w_out), 16'(wd ? x[7:0] : w));
      chk(16'(status_flags), 16'((rv | fs | lt) ? x[12:8] : {fl[4:1], c}));
   endtask

   initial begin
      logic [15:0] k;
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      foreach (CV[i]) op(CV[i][32:17], CV[i][16:9], CV[i][8:1], CV[i][0]);
      $display("corner tests done");
      for (int i = 0; i < 240; i++) begin
         k = 16'($random(seed));
         case (i % 4)
            0: k[15:10] = 6'h15;
            1: k[15:10] = 6'h17;
            2: k[15:8] = 8'h08;
            default: ;
         endcase
         op(k, 8'($random(seed)), 8'($random(seed)), 1'($random(seed)));
      end
      $display("random tests done");
      test_done;
   end

   // About ten times the expected run of some 3000 cycles
   initial begin
      #3000000;
      errors++;
      test_done;
   end
endmodule // tb
